// ---- rtl/sfpw_sequencer.sv ----
// Page program sequencer with per-unit error correction and AXI4-Lite registers
// What this block does
// - Every aligned 16-byte unit gets check bits computed and stored while programming.
// - A second program of a unit before erase sets its correction-disable flag.
// - Each unit holds eight check bits plus one disable flag.
// - Sector erase restores all main-sector check bits and disable flags to enabled.
// - Reads of a disabled unit return stored data with no correction.
// - Reads of an enabled unit correct single-bit errors automatically.
// - Correction covers main and one-time region, never the registers.
// - One-time region units stay disabled forever after a second program.
// - A status read reports correction enabled and errors corrected per unit.
// - Page buffer holds 512 bytes, page aligned; one byte up to one page.
// - Write-enable command sets the latch; page program refused while latch clear.
// - Opcode 02h takes three or four address bytes; 12h always four.
// - Data past page end wraps to page start; low nine bits address.
// - Short loads program in sequence and leave other page bytes untouched.
// - Programming only clears bits; at least one data byte is required.
// - Write-in-progress stays high while programming; failure sets program error.
// - Four-lane loads take four data bits per clock, up to one page.
// - Four-lane program accepted only with four-lane enable and latch set.
// - Opcodes 32h and 38h follow extended address; 34h takes four bytes.
// - Four-lane enable is configuration bit one.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
module sfpw_sequencer (
    input wire logic clk,
    input wire logic rst,
    input wire sfpw_pkg::sfpw_spi_in_type spi_in,
    output sfpw_pkg::sfpw_spi_out_type spi_out,
    input wire sfpw_pkg::sfpw_axi_req_type axi_req,
    output sfpw_pkg::sfpw_axi_rsp_type axi_rsp
);
    import sfpw_pkg::*;

    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] s3;
        logic [5:0] filt;
        sfpw_phase_type ph;
        logic [5:0] bitcnt;
        logic [7:0] shreg;
        logic [31:0] addr;
        logic [5:0] addr_bits;
        logic quad;
        logic [8:0] ptr;
        logic got_byte;
        logic [PAGE_BYTES-1:0] mask;
        logic write_enable_latch;
        logic write_in_progress;
        logic perr;
        logic [7:0] cfg;
        logic [4:0] walk;
        logic [7:0] base;
        logic [31:0] rd_addr;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sfpw_state_type;

    sfpw_state_type r;
    sfpw_state_type n;

    // Page buffer and array model: data, check bits, disable flag, programmed flag
    logic [7:0] pbuf [PAGE_BYTES];
    logic [UNIT_BITS-1:0] flash_data [TOTAL_UNITS];
    logic [CHECK_BITS-1:0] flash_chk [TOTAL_UNITS];
    logic flash_dis [TOTAL_UNITS];
    logic flash_used [TOTAL_UNITS];

    logic buf_we;
    logic [8:0] buf_idx;
    logic [7:0] buf_byte;
    logic unit_we;
    logic [7:0] unit_idx;
    logic [UNIT_BITS-1:0] unit_old;
    logic [UNIT_BITS-1:0] unit_new;
    logic [15:0] unit_mask;
    logic unit_used_old;
    logic erase_go;
    logic inject_go;
    logic [15:0] inject_val;
    logic [7:0] rd_unit;
    logic [7:0] syn;
    logic [UNIT_BITS-1:0] rd_fixed;
    logic rd_data_err;
    logic rd_chk_err;
    logic sck_rise;
    logic cs_rise;
    logic cs_fall;
    logic opc_done;
    logic byte_done;
    logic region_bad;
    logic [7:0] opc_byte;
    logic [7:0] data_byte;
    logic aw_take;
    logic ar_take;

    // Code position of data bit i: the i-th position that is not a power of two
    function automatic logic [7:0] ecc_pos(input int i);
        int cnt;
        logic [7:0] res;
        cnt = 0;
        res = 8'h00;
        for (int p = 3; p < 140; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (cnt == i) begin
                    res = 8'(p);
                end
                cnt++;
            end
        end
        return res;
    endfunction

    // Single-error-correcting code over one 128-bit unit
    function automatic logic [7:0] ecc_calc(input logic [UNIT_BITS-1:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < UNIT_BITS; i++) begin
            if (d[i]) begin
                c = c ^ ecc_pos(i);
            end
        end
        return c;
    endfunction

    // Check code of an erased unit, worked out once so reset loads a constant
    localparam logic [CHECK_BITS-1:0] ERASED_CHECK = ecc_calc('1);

    // Correction applies to array reads only; registers never pass through it
    always_comb begin
        rd_unit = r.cfg[CFG_OTP_BIT] ? (OTP_BASE + {2'b00, r.rd_addr[9:4]})
                                     : {1'b0, r.rd_addr[10:4]};
        syn = flash_chk[rd_unit] ^ ecc_calc(flash_data[rd_unit]);
        rd_fixed = flash_data[rd_unit];
        rd_data_err = 1'b0;
        rd_chk_err = 1'b0;
        // Disabled units are returned raw
        if (!flash_dis[rd_unit] && (syn != 8'h00)) begin
            if ((syn & (syn - 8'h01)) == 8'h00) begin
                rd_chk_err = 1'b1;
            end else begin
                for (int i = 0; i < UNIT_BITS; i++) begin
                    if (ecc_pos(i) == syn) begin
                        rd_fixed[i] = ~rd_fixed[i];
                        rd_data_err = 1'b1;
                    end
                end
            end
        end
    end

    // Unit merge for the program walk: untouched bytes keep their old value
    always_comb begin
        unit_idx = r.base + {3'b000, r.walk};
        unit_old = flash_data[unit_idx];
        unit_used_old = flash_used[unit_idx];
        unit_mask = r.mask[{r.walk, 4'h0} +: UNIT_BYTES];
        unit_new = unit_old;
        for (int k = 0; k < UNIT_BYTES; k++) begin
            if (unit_mask[k]) begin
                unit_new[8*k +: 8] = unit_old[8*k +: 8] & pbuf[{r.walk, 4'(k)}];
            end
        end
        unit_we = (r.ph == PH_PROG) && (unit_mask != 16'h0000);
    end

    // Pin edges from the filtered levels; stage one is read only by stage two
    assign sck_rise = (r.s2[5] == r.s3[5]) && r.s3[5] && !r.filt[5];
    assign cs_rise = (r.s2[4] == r.s3[4]) && r.s3[4] && !r.filt[4];
    assign cs_fall = (r.s2[4] == r.s3[4]) && !r.s3[4] && r.filt[4];
    assign opc_byte = {r.shreg[6:0], r.s3[0]};
    assign data_byte = r.quad ? {r.shreg[3:0], r.s3[3:0]} : {r.shreg[6:0], r.s3[0]};
    assign opc_done = sck_rise && !r.filt[4] && (r.ph == PH_OPC)
                      && (r.bitcnt == LAST_BIT_SINGLE);
    assign byte_done = sck_rise && !r.filt[4] && (r.ph == PH_DATA)
                       && (r.bitcnt == (r.quad ? LAST_BIT_QUAD : LAST_BIT_SINGLE));
    assign region_bad = r.cfg[CFG_OTP_BIT] ? (r.addr[31:10] != 22'h00_0000)
                                           : (r.addr[31:11] != 21'h00_0000);
    assign aw_take = axi_req.awvalid && axi_req.wvalid && !r.bvalid;
    assign ar_take = axi_req.arvalid && !r.rvalid;

    // Slave handshakes are combinational, answers come from flip-flops
    always_comb begin
        axi_rsp.awready = aw_take;
        axi_rsp.wready = aw_take;
        axi_rsp.bvalid = r.bvalid;
        axi_rsp.bresp = r.bresp;
        axi_rsp.arready = ar_take;
        axi_rsp.rvalid = r.rvalid;
        axi_rsp.rdata = r.rdata;
        axi_rsp.rresp = r.rresp;
        spi_out.io_out = 4'h0;
        spi_out.io_oe = 4'h0;
    end

    // Next-state logic: register writes first so hardware sets win over clears
    always_comb begin
        n = r;
        buf_we = 1'b0;
        buf_idx = r.ptr;
        buf_byte = data_byte;
        erase_go = 1'b0;
        inject_go = 1'b0;
        inject_val = axi_req.wdata[15:0];
        n.s1 = {spi_in.sck, spi_in.cs_n, spi_in.io};
        n.s2 = r.s1;
        n.s3 = r.s2;
        for (int b = 0; b < 6; b++) begin
            if (r.s2[b] == r.s3[b]) begin
                n.filt[b] = r.s3[b];
            end
        end
        // AXI4-Lite write: address and data taken together
        if (r.bvalid && axi_req.bready) begin
            n.bvalid = 1'b0;
        end
        if (aw_take) begin
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            case (axi_req.awaddr)
                REG_STATUS: begin
                    if (axi_req.wstrb[0] && axi_req.wdata[SR_PERR_BIT]) begin
                        n.perr = 1'b0;
                    end
                end
                REG_CONFIG: begin
                    if (axi_req.wstrb[0]) begin
                        n.cfg = axi_req.wdata[7:0];
                    end
                end
                REG_ERASE: begin
                    erase_go = axi_req.wstrb[0] && axi_req.wdata[0] && !r.write_in_progress;
                end
                REG_RD_ADDR: begin
                    n.rd_addr = axi_req.wdata;
                end
                REG_INJECT: begin
                    inject_go = 1'b1;
                end
                REG_RD_DATA, REG_CORR_STATUS: begin
                end
                default: begin
                    n.bresp = RESP_SLVERR;
                end
            endcase
        end
        // AXI4-Lite read
        if (r.rvalid && axi_req.rready) begin
            n.rvalid = 1'b0;
        end
        if (ar_take) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = 32'h0000_0000;
            case (axi_req.araddr)
                REG_STATUS: begin
                    n.rdata[SR_WIP_BIT] = r.write_in_progress;
                    n.rdata[SR_WEL_BIT] = r.write_enable_latch;
                    n.rdata[SR_PERR_BIT] = r.perr;
                end
                REG_CONFIG: n.rdata[7:0] = r.cfg;
                REG_RD_ADDR: n.rdata = r.rd_addr;
                REG_RD_DATA: n.rdata[7:0] = rd_fixed[{r.rd_addr[3:0], 3'b000} +: 8];
                REG_CORR_STATUS: n.rdata[2:0] = {rd_chk_err, rd_data_err, flash_dis[rd_unit]};
                REG_ERASE, REG_INJECT: begin
                end
                default: n.rresp = RESP_SLVERR;
            endcase
        end
        // Serial command decoding
        if (cs_rise) begin
            if (r.ph == PH_DATA && r.got_byte && r.bitcnt == 6'h00) begin
                if (region_bad) begin
                    n.perr = 1'b1;
                    n.write_enable_latch = 1'b0;
                    n.ph = PH_IDLE;
                end else begin
                    n.ph = PH_PROG;
                    n.write_in_progress = 1'b1;
                    n.walk = 5'h00;
                    n.base = r.cfg[CFG_OTP_BIT] ? (OTP_BASE + {2'b00, r.addr[9], 5'h00})
                                                : {1'b0, r.addr[10:9], 5'h00};
                end
            end else if (r.ph != PH_PROG) begin
                n.ph = PH_IDLE;
            end
        end else if (cs_fall && r.ph == PH_IDLE) begin
            n.ph = PH_OPC;
            n.bitcnt = 6'h00;
        end else if (sck_rise && !r.filt[4]) begin
            case (r.ph)
                PH_OPC: begin
                    n.shreg = opc_byte;
                    n.bitcnt = r.bitcnt + STEP_SINGLE;
                    if (opc_done) begin
                        n.ph = PH_SKIP;
                        n.bitcnt = 6'h00;
                        n.addr = 32'h0000_0000;
                        n.mask = '0;
                        n.got_byte = 1'b0;
                        case (opc_byte)
                            OPC_WRITE_ENABLE: begin
                                n.write_enable_latch = r.write_enable_latch || !r.write_in_progress;
                            end
                            OPC_PAGE_WRITE, OPC_PAGE_WRITE_WIDE: begin
                                if (r.write_enable_latch && !r.write_in_progress) begin
                                    n.ph = PH_ADDR;
                                    n.quad = 1'b0;
                                    n.addr_bits = (opc_byte == OPC_PAGE_WRITE_WIDE
                                        || r.cfg[CFG_EXT_BIT]) ? ADDR_BITS_LONG
                                                               : ADDR_BITS_SHORT;
                                end
                            end
                            OPC_FOUR_LANE_A, OPC_FOUR_LANE_B, OPC_FOUR_LANE_WIDE: begin
                                if (r.write_enable_latch && !r.write_in_progress && r.cfg[CFG_QUAD_BIT]) begin
                                    n.ph = PH_ADDR;
                                    n.quad = 1'b1;
                                    n.addr_bits = (opc_byte == OPC_FOUR_LANE_WIDE
                                        || r.cfg[CFG_EXT_BIT]) ? ADDR_BITS_LONG
                                                               : ADDR_BITS_SHORT;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                PH_ADDR: begin
                    n.addr = {r.addr[30:0], r.s3[0]};
                    n.bitcnt = r.bitcnt + STEP_SINGLE;
                    if (r.bitcnt == r.addr_bits - STEP_SINGLE) begin
                        n.ph = PH_DATA;
                        n.bitcnt = 6'h00;
                        n.ptr = n.addr[8:0];
                    end
                end
                PH_DATA: begin
                    n.shreg = data_byte;
                    n.bitcnt = r.bitcnt + (r.quad ? STEP_QUAD : STEP_SINGLE);
                    if (byte_done) begin
                        buf_we = 1'b1;
                        n.mask[r.ptr] = 1'b1;
                        n.ptr = r.ptr + 9'h001;
                        n.got_byte = 1'b1;
                        n.bitcnt = 6'h00;
                    end
                end
                default: begin
                end
            endcase
        end
        // Program walk: one correction unit per cycle across the page
        if (r.ph == PH_PROG) begin
            n.walk = r.walk + 5'h01;
            if (r.walk == LAST_WALK) begin
                n.ph = PH_IDLE;
                n.write_in_progress = 1'b0;
                n.write_enable_latch = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.s1 <= 6'h10;
            r.s2 <= 6'h10;
            r.s3 <= 6'h10;
            r.filt <= 6'h10;
            r.ph <= PH_IDLE;
            r.cfg <= CFG_RESET;
        end else begin
            r <= n;
        end
    end

    // Page buffer write port; no reset since only bytes marked in mask are used
    always_ff @(posedge clk) begin
        if (buf_we) begin
            pbuf[buf_idx] <= buf_byte;
        end
    end

    // Array model: reset leaves all units, erase the main units, erased with correction enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int u = 0; u < TOTAL_UNITS; u++) begin
                flash_data[u] <= '1;
                flash_chk[u] <= ERASED_CHECK;
                flash_dis[u] <= 1'b0;
                flash_used[u] <= 1'b0;
            end
        end else begin
            if (erase_go) begin
                // Only the main sector is erased; the one-time region never is
                for (int u = 0; u < MAIN_UNITS; u++) begin
                    flash_data[u] <= '1;
                    flash_chk[u] <= ERASED_CHECK;
                    flash_dis[u] <= 1'b0;
                    flash_used[u] <= 1'b0;
                end
            end else if (unit_we) begin
                flash_data[unit_idx] <= unit_new;
                flash_used[unit_idx] <= 1'b1;
                if (unit_used_old) begin
                    flash_dis[unit_idx] <= 1'b1;
                end else begin
                    flash_chk[unit_idx] <= ecc_calc(unit_new);
                end
            end else if (inject_go) begin
                // Fault injection lets software exercise the correction path
                flash_data[rd_unit][{r.rd_addr[3:0], 3'b000} +: 8] <=
                    flash_data[rd_unit][{r.rd_addr[3:0], 3'b000} +: 8] ^ inject_val[7:0];
                flash_chk[rd_unit] <= flash_chk[rd_unit] ^ inject_val[15:8];
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence prog_start_s;
        cs_rise && r.ph == PH_DATA && r.got_byte && r.bitcnt == 6'h00 && !region_bad;
    endsequence

    sequence prog_run_s;
        r.write_in_progress [*8] ##[1:40] !r.write_in_progress;
    endsequence

    prog_run_a: assert property (prog_start_s |=> prog_run_s)
        else $error("write in progress did not span the program walk");
    prog_busy_a: assert property (r.ph == PH_PROG |-> r.write_in_progress && r.write_enable_latch)
        else $error("program walk running without busy and latch");
    wel_gate_a: assert property (opc_done && !r.write_enable_latch |=> r.ph == PH_SKIP)
        else $error("program command accepted with latch clear");
    quad_gate_a: assert property (opc_done && !r.cfg[CFG_QUAD_BIT]
        && (opc_byte == OPC_FOUR_LANE_A || opc_byte == OPC_FOUR_LANE_B
        || opc_byte == OPC_FOUR_LANE_WIDE) |=> r.ph == PH_SKIP)
        else $error("four-lane command accepted with lane enable clear");
    page_wrap_a: assert property (byte_done |=> r.ptr == 9'($past(r.ptr) + 9'h001))
        else $error("page pointer did not wrap within the page");
    one_to_zero_a: assert property (unit_we |-> (unit_new & ~unit_old) == '0)
        else $error("program raised a bit from zero to one");
    second_prog_a: assert property (unit_we && unit_used_old && !erase_go
        |=> flash_dis[$past(unit_idx)])
        else $error("second program left correction enabled");
    erase_clear_a: assert property (erase_go |=> !flash_dis[0] && !flash_used[0])
        else $error("erase did not restore correction");
    otp_keep_a: assert property (!$fell(flash_dis[TOTAL_UNITS-1]))
        else $error("one-time region correction was re-enabled");
    midbyte_drop_a: assert property (cs_rise && r.ph == PH_DATA && r.bitcnt != 6'h00
        |=> r.ph == PH_IDLE && !r.write_in_progress)
        else $error("partial byte started a program");

endmodule

// ---- shared/sfpw_pkg.sv ----
// Shared constants and carrier types for the serial flash page write sequencer
package sfpw_pkg;

    // Clock and link figures
    localparam int CLK_PERIOD_NS = 8;
    localparam int LINK_PERIOD_NS = 125;

    // Command opcodes
    localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OPC_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OPC_PAGE_WRITE_WIDE = 8'h12;
    localparam logic [7:0] OPC_FOUR_LANE_A = 8'h32;
    localparam logic [7:0] OPC_FOUR_LANE_B = 8'h38;
    localparam logic [7:0] OPC_FOUR_LANE_WIDE = 8'h34;

    // Serial framing counts
    localparam logic [5:0] LAST_BIT_SINGLE = 6'h07;
    localparam logic [5:0] LAST_BIT_QUAD = 6'h04;
    localparam logic [5:0] STEP_SINGLE = 6'h01;
    localparam logic [5:0] STEP_QUAD = 6'h04;
    localparam logic [5:0] ADDR_BITS_SHORT = 6'h18;
    localparam logic [5:0] ADDR_BITS_LONG = 6'h20;

    // Geometry: 512-byte page, 16-byte correction unit, small array model
    localparam int PAGE_BYTES = 512;
    localparam int UNIT_BYTES = 16;
    localparam int UNIT_BITS = 128;
    localparam int UNITS_PER_PAGE = 32;
    localparam int CHECK_BITS = 8;
    localparam int MAIN_UNITS = 128;
    localparam int OTP_UNITS = 64;
    localparam int TOTAL_UNITS = 192;
    localparam logic [7:0] OTP_BASE = 8'h80;
    localparam logic [4:0] LAST_WALK = 5'h1f;

    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CONFIG = 8'h04;
    localparam logic [7:0] REG_ERASE = 8'h08;
    localparam logic [7:0] REG_RD_ADDR = 8'h0c;
    localparam logic [7:0] REG_RD_DATA = 8'h10;
    localparam logic [7:0] REG_CORR_STATUS = 8'h14;
    localparam logic [7:0] REG_INJECT = 8'h18;

    // Field positions and reset values
    localparam int SR_WIP_BIT = 0;
    localparam int SR_WEL_BIT = 1;
    localparam int SR_PERR_BIT = 6;
    localparam int CFG_QUAD_BIT = 1;
    localparam int CFG_OTP_BIT = 2;
    localparam int CFG_EXT_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Serial pins: three-stage sampled inputs and two-way pin drive
    typedef struct packed {
        logic sck;
        logic cs_n;
        logic [3:0] io;
    } sfpw_spi_in_type;

    typedef struct packed {
        logic [3:0] io_out;
        logic [3:0] io_oe;
    } sfpw_spi_out_type;

    // AXI4-Lite master-to-slave and slave-to-master groups
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } sfpw_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sfpw_axi_rsp_type;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_OPC = 3'b001,
        PH_ADDR = 3'b010,
        PH_DATA = 3'b011,
        PH_SKIP = 3'b100,
        PH_PROG = 3'b101
    } sfpw_phase_type;

endpackage

// ---- bench/sfpw_host.sv ----
// Host model that frames serial program commands on the four data lines
module sfpw_host (
    output sfpw_pkg::sfpw_spi_in_type spi
);
    timeunit 1ns;
    timeprecision 1ns;
    // Clock parked low, chip select high between frames
    initial spi = 6'h10;
    // Deselected lines keep changing so stale bits never look valid
    always #62 if (spi.cs_n) spi.io = ~spi.io;
    // Header bits one at a time on io[0], data w bits per clock, MSB first
    task automatic frame(input logic [67:0] v, input int nh, input int nd, input int w);
        int s;
        spi.cs_n = 1'b0;
        for (int i = nh + nd; i > 0; i -= s) begin
            s = (i > nd) ? 1 : w;
            spi.io = v[i - s +: 4];
            #62 spi.sck = 1'b1;
            #63 spi.sck = 1'b0;
        end
        #125 spi.cs_n = 1'b1;
        #125;
    endtask
endmodule

// ---- bench/tb_serial_flash_page_program.sv ----
// Self-checking bench: host frames and register traffic against a byte model
module tb_serial_flash_page_program;
    timeunit 1ns;
    timeprecision 1ns;
    import sfpw_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    sfpw_spi_in_type spi;
    sfpw_spi_out_type so;
    sfpw_axi_req_type q = '0;
    sfpw_axi_rsp_type r;
    logic [31:0] d;
    logic [1:0] br;
    logic [7:0] mem [2048];
    logic [7:0] ops [4] = '{OPC_PAGE_WRITE, OPC_FOUR_LANE_A, OPC_FOUR_LANE_B, OPC_FOUR_LANE_WIDE};
    bit pg [128], dis [128], write_enable_latch, quad;
    int n_errors = 0;
    int cmp_count = 0;
    sfpw_host host (.spi(spi));
    sfpw_sequencer uut (.clk(clk), .rst(rst), .spi_in(spi), .spi_out(so), .axi_req(q), .axi_rsp(r));
    initial forever #4 clk = ~clk;
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Bus write: address and data held together until awready, bready until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        q <= '{'1, a, '1, v, '1, '1, '0, '0, '0};
        do @(posedge clk); while (r.awready !== 1'b1);
        q.awvalid <= 1'b0;
        q.wvalid <= 1'b0;
        do @(posedge clk); while (r.bvalid !== 1'b1);
        q.bready <= 1'b0;
        br = r.bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        q.arvalid <= 1'b1;
        q.araddr <= a;
        q.rready <= 1'b1;
        do @(posedge clk); while (r.arready !== 1'b1);
        q.arvalid <= 1'b0;
        do @(posedge clk); while (r.rvalid !== 1'b1);
        q.rready <= 1'b0;
        d = r.rdata;
        br = r.rresp;
    endtask
    // Erased state: all ones, no unit programmed yet
    task automatic blank;
        foreach (mem[i]) mem[i] = 8'hff;
        pg = '{default: 0};
        dis = '{default: 0};
    endtask
    // Poll long enough to span the whole program walk
    task automatic settle(input bit ok);
        bit seen;
        seen = 0;
        repeat (30) begin
            rd(REG_STATUS);
            seen |= d[0];
        end
        chk("wip_seen", 32'(ok), 32'(seen));
        chk("status", {30'h0, write_enable_latch, 1'b0}, d);
        chk("io_drive", 32'h0, 32'(so));
    endtask
    task automatic write_enable_cmd;
        host.frame(68'(OPC_WRITE_ENABLE), 8, 0, 1);
        write_enable_latch = 1;
        rd(REG_STATUS);
        chk("wel", 32'h2, d);
    endtask
    // One program frame of random bytes, mirrored on the model when accepted
    task automatic prog(input logic [7:0] op, input int ab, input int a, input int nb, input int w);
        logic [67:0] v;
        logic [7:0] b;
        bit ok;
        bit t [128];
        int i;
        ok = write_enable_latch && (w == 1 || quad);
        v = (68'(op) << (8 * ab)) | 68'(a);
        for (int j = 0; j < nb; j++) begin
            b = 8'($urandom);
            v = (v << 8) | 68'(b);
            i = a - a % 512 + (a + j) % 512;
            if (ok) mem[i] &= b;
            t[i / 16] = 1'b1;
        end
        host.frame(v, 8 + 8 * ab, 8 * nb, w);
        if (ok) write_enable_latch = 0;
        foreach (t[u]) begin
            dis[u] |= ok & t[u] & pg[u];
            pg[u] |= ok & t[u];
        end
        settle(ok);
    endtask
    // Read a byte back with its correction status; x and c add expected error marks
    task automatic peek(input int a, input logic [7:0] x, input logic [31:0] c);
        wr(REG_RD_ADDR, 32'(a));
        rd(REG_RD_DATA);
        chk("byte", 32'(mem[a] ^ x), d);
        rd(REG_CORR_STATUS);
        chk("corr", 32'(dis[a / 16]) | c, d);
    endtask
    // Watchdog: the sequence needs well under half of this span
    initial begin
        #400000;
        n_errors++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'h11ff));
        blank;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(REG_CONFIG);
        chk("cfg_rst", 32'(CFG_RESET), d);
        wr(8'h40, 32'h0);
        chk("bresp", 32'(RESP_SLVERR), 32'(br));
        prog(OPC_PAGE_WRITE, 3, 32'h1fe, 2, 1);
        write_enable_cmd;
        prog(OPC_PAGE_WRITE, 3, 32'h1fe, 4, 1);
        for (int k = -3; k < 3; k++) peek((k + 512) % 512, 0, 0);
        write_enable_cmd;
        prog(OPC_PAGE_WRITE_WIDE, 4, 32'h8, 2, 1);
        peek(8, 0, 0);
        wr(REG_CONFIG, 32'h82);
        quad = 1;
        foreach (ops[n]) begin
            write_enable_cmd;
            prog(ops[n], 4, 32'h400 + 32 * n, 3, n == 0 ? 1 : 4);
            peek(32'h401 + 32 * n, 0, 0);
        end
        wr(REG_CONFIG, 32'h80);
        quad = 0;
        write_enable_cmd;
        prog(OPC_FOUR_LANE_WIDE, 4, 32'h500, 2, 4);
        host.frame(68'({OPC_PAGE_WRITE_WIDE, 32'h600, 12'h5a5}), 40, 12, 1);
        settle(0);
        peek(32'h600, 0, 0);
        // Address past the modelled array: program error, latch dropped, no walk
        write_enable_cmd;
        host.frame(68'({OPC_PAGE_WRITE_WIDE, 32'h800, 8'h00}), 40, 8, 1);
        rd(REG_STATUS);
        chk("perr", 32'h40, d);
        wr(REG_STATUS, 32'h40);
        write_enable_latch = 0;
        settle(0);
        wr(REG_INJECT, 32'h1);
        peek(32'h600, 8'h00, 32'h2);
        wr(REG_RD_ADDR, 32'h0);
        wr(REG_INJECT, 32'h1);
        peek(0, 8'h01, 0);
        wr(REG_ERASE, 32'h1);
        blank;
        peek(0, 0, 0);
        // One-time region: a second program disables correction, erase cannot undo it
        wr(REG_CONFIG, 32'h84);
        repeat (2) begin
            write_enable_cmd;
            host.frame(68'({OPC_PAGE_WRITE_WIDE, 32'h10, 8'h5a}), 40, 8, 1);
            write_enable_latch = 0;
            settle(1);
        end
        wr(REG_ERASE, 32'h1);
        wr(REG_RD_ADDR, 32'h10);
        rd(REG_RD_DATA);
        chk("otp_byte", 32'h5a, d);
        rd(REG_CORR_STATUS);
        chk("otp_corr", 32'h1, d);
        report_and_stop;
    end
endmodule
